// ---- src/sol_in_map.sv ----
// maps the input terminals onto home switch and over-travel functions
`timescale 1ns/1ps
`include "sol_map.svh"
module sol_in_map (
  input wire logic [`SOL_N_IN-1:0] cont_in, // input terminal levels
  input wire sol_pkg::sol_code_type codes [`SOL_N_IN], // active input assignments
  output logic home_on, // home switch level
  output logic pos_ok, // positive limit not reached
  output logic neg_ok // negative limit not reached
);
  import sol_pkg::*;
  // terminals whose assignment equals a function code
  function automatic logic [`SOL_N_IN-1:0] hits(input sol_code_type c [`SOL_N_IN], input sol_code_type want);
    for (int i = 0; i < `SOL_N_IN; i++) begin
      hits[i] = (c[i] == want);
    end
  endfunction : hits
  // unassigned home reads off; unassigned limits read on (break contacts)
  always_comb begin
    home_on = |(cont_in & hits(codes, `SOL_FI_HOME));
    pos_ok = &(cont_in | ~hits(codes, `SOL_FI_POT));
    neg_ok = &(cont_in | ~hits(codes, `SOL_FI_NOT));
  end
endmodule : sol_in_map

// ---- src/sol_map.svh ----
// register offsets, field positions, codes and sizes of the sequence i/o block
`ifndef SOL_MAP_SVH
`define SOL_MAP_SVH
`define SOL_N_OUT 12
`define SOL_N_IN 6
`define SOL_A_CTRL 8'h00
`define SOL_A_STS 8'h04
`define SOL_A_MASK 8'h08
`define SOL_A_PMAX 8'h0C
`define SOL_A_PMIN 8'h10
`define SOL_A_LIVE 8'h14
`define SOL_A_OUT0 8'h20
`define SOL_A_IN0 8'h50
`define SOL_C_ROT 0
`define SOL_C_STOP 1
`define SOL_C_SWEN 2
`define SOL_C_DO1 3
`define SOL_C_DO2 4
`define SOL_E_POT 0
`define SOL_E_NOT 1
`define SOL_E_SWOT 2
`define SOL_CTRL_RST 5'h00
`define SOL_PMAX_RST 32'h7FFFFFFF
`define SOL_PMIN_RST 32'h80000000
`define SOL_CODE_RST 7'h00
`define SOL_FC_RDY 7'h01
`define SOL_FC_INP 7'h02
`define SOL_FC_ALM_NO 7'h10
`define SOL_FC_OT 7'h14
`define SOL_FC_HOMED 7'h16
`define SOL_FC_ZSPD 7'h18
`define SOL_FC_CRDY 7'h1C
`define SOL_FC_POT 7'h26
`define SOL_FC_NOT 7'h27
`define SOL_FC_HOME 7'h28
`define SOL_FC_FSTOP 7'h29
`define SOL_FC_PRESET 7'h4B
`define SOL_FC_ALM_NC 7'h4C
`define SOL_FC_DO1 7'h5B
`define SOL_FC_DO2 7'h5C
`define SOL_FI_HOME 7'h06
`define SOL_FI_POT 7'h07
`define SOL_FI_NOT 7'h08
`endif

// ---- src/sol_out_sel.sv ----
// picks the status that one output terminal shows from its function code
`timescale 1ns/1ps
`include "sol_map.svh"
module sol_out_sel (
  input wire sol_pkg::sol_code_type code, // terminal assignment
  input wire logic dout_ok, // terminal may carry digital outputs
  input wire sol_pkg::sol_stat_type st, // internal status
  output logic level // terminal drive level
);
  import sol_pkg::*;
  // code selects the function; unknown codes stay inactive
  always_comb begin
    case (code)
      `SOL_FC_RDY: level = st.rdy;
      `SOL_FC_INP: level = st.inp;
      `SOL_FC_ALM_NO: level = st.alarm;
      `SOL_FC_ALM_NC: level = !st.alarm;
      `SOL_FC_OT: level = st.ot;
      `SOL_FC_HOMED: level = st.homed;
      `SOL_FC_ZSPD: level = st.zspd;
      `SOL_FC_CRDY: level = st.crdy;
      `SOL_FC_POT: level = st.pot;
      `SOL_FC_NOT: level = st.nott;
      `SOL_FC_HOME: level = st.home;
      `SOL_FC_FSTOP: level = st.fstop;
      `SOL_FC_PRESET: level = st.preset;
      `SOL_FC_DO1: level = dout_ok && st.do1;
      `SOL_FC_DO2: level = dout_ok && st.do2;
      default: level = 1'b0;
    endcase
  end
endmodule : sol_out_sel

// ---- src/sol_pkg.sv ----
// types shared by the sequence i/o and over-travel block
package sol_pkg;
  typedef logic [6:0] sol_code_type; // terminal function code
  typedef logic signed [31:0] sol_pos_type; // axis position
  typedef struct packed {
    logic do2, do1, pot, nott, ot, alarm, preset, fstop;
    logic home, crdy, zspd, homed, inp, rdy;
  } sol_stat_type; // internal status functions
endpackage : sol_pkg

// ---- src/sol_seq_io.sv ----
// sequence output mapping, limit inputs and software over-travel with apb registers
// How it works
// - twelve output codes, default zero, apply at power cycle
// - each output shows status chosen by code
// - alarm as open (16) or closed (76) contact
// - digital outputs 91, 92 only on first two
// - home switch from input code 6, else off
// - home switch serves homing chosen by host
// - positive limit code 7, negative code 8
// - unassigned limit reads on; off means reached
// - hardware limits ignored under torque control
// - limit hit decelerates using chosen stop method
// - opposite-direction motion still allowed at limit
// - positive limit acts only on positive travel
// - per-limit detection on codes 38, 39
// - code 20 shows any hardware or software limit
// - software window enforced when selection is one
// - leaving window forces stop, raises code 20
// - travelling back clears software limit indication
`timescale 1ns/1ps
`include "sol_map.svh"
module sol_seq_io (
  input wire logic pclk, // control clock
  input wire logic presetn, // async reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic power_cycle, // supply restart pulse, applies settings
  input wire logic [`SOL_N_IN-1:0] cont_in, // sequence input terminals
  input wire logic motor_fwd, // motor turning forward
  input wire logic motor_rev, // motor turning reverse
  input wire logic torque_mode, // torque control active
  input wire sol_pkg::sol_pos_type cur_pos, // current position
  input wire logic servo_ready, // servo-on ready status
  input wire logic in_position, // in-position status
  input wire logic homing_done, // homing complete status
  input wire logic zero_speed, // zero speed status
  input wire logic ctrl_ready, // control ready status
  input wire logic fstop_seen, // forced stop status
  input wire logic preset_done, // preset complete status
  input wire logic alarm, // alarm present
  output logic [`SOL_N_OUT-1:0] seq_out, // sequence output terminals
  output logic home_limit_switch, // home switch to homing logic
  output logic stop_req, // decelerate to stop
  output logic third_torque_limit_sel, // stop by torque limit, else quick-stop decel
  output logic inhibit_pos, // block positive motion commands
  output logic inhibit_neg, // block negative motion commands
  output logic irq // level interrupt
);
  import sol_pkg::*;

  logic [4:0] ctrl_reg; // control bits
  logic [2:0] sts_reg; // sticky events
  logic [2:0] mask_reg; // interrupt enables
  sol_pos_type pmax_reg; // window maximum
  sol_pos_type pmin_reg; // window minimum
  sol_code_type out_pend [`SOL_N_OUT]; // written output assignments
  sol_code_type out_act [`SOL_N_OUT]; // applied output assignments
  sol_code_type in_pend [`SOL_N_IN]; // written input assignments
  sol_code_type in_act [`SOL_N_IN]; // applied input assignments
  logic pos_ot_reg; // positive hardware limit seen
  logic neg_ot_reg; // negative hardware limit seen
  logic sw_pos_reg; // above window
  logic sw_neg_reg; // below window
  logic sw_pos_next; // next above-window state
  logic sw_neg_next; // next below-window state
  logic home_on, pos_ok, neg_ok; // mapped input functions
  logic travel_pos, travel_neg; // travel direction in axis terms
  logic pos_hit, neg_hit; // limits acting this cycle
  logic [2:0] evt; // event set pulses
  logic [`SOL_N_OUT-1:0] sel; // selected terminal levels
  sol_stat_type st; // status bundle for the selectors
  logic acc, wr_en; // apb access phase and write strobe
  logic [31:0] rd_val; // decoded read value
  logic rd_ok; // address is mapped

  // apb decode: read value and mapping of an address
  function automatic logic [32:0] decode(input logic [7:0] a);
    decode = {1'b1, 32'h00000000};
    if (a == `SOL_A_CTRL) begin
      decode[4:0] = ctrl_reg;
    end else if (a == `SOL_A_STS) begin
      decode[2:0] = sts_reg;
    end else if (a == `SOL_A_MASK) begin
      decode[2:0] = mask_reg;
    end else if (a == `SOL_A_PMAX) begin
      decode[31:0] = pmax_reg;
    end else if (a == `SOL_A_PMIN) begin
      decode[31:0] = pmin_reg;
    end else if (a == `SOL_A_LIVE) begin
      decode[4:0] = {home_on, sw_neg_reg, sw_pos_reg, neg_ot_reg, pos_ot_reg};
    end else if (a >= `SOL_A_OUT0 && a < `SOL_A_IN0 && a[1:0] == 2'b00) begin
      decode[6:0] = out_pend[4'((a - `SOL_A_OUT0) >> 2)];
    end else if (a >= `SOL_A_IN0 && a < 8'h68 && a[1:0] == 2'b00) begin
      decode[6:0] = in_pend[3'((a - `SOL_A_IN0) >> 2)];
    end else begin
      decode[32] = 1'b0; // unmapped
    end
  endfunction : decode

  // read mux as a process, so that register changes reach it without an address change
  always_comb begin
    {rd_ok, rd_val} = decode(paddr);
  end
  // access phase not yet answered; the write lands on the edge that samples ready
  assign acc = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && rd_ok;

  // one wait state: ready and read data registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc;
      pslverr <= acc && !rd_ok;
      if (acc && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // control, window and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SOL_CTRL_RST;
      mask_reg <= 3'h0;
      pmax_reg <= `SOL_PMAX_RST;
      pmin_reg <= `SOL_PMIN_RST;
    end else if (wr_en) begin
      if (paddr == `SOL_A_CTRL) begin
        ctrl_reg <= pwdata[4:0];
      end else if (paddr == `SOL_A_MASK) begin
        mask_reg <= pwdata[2:0];
      end else if (paddr == `SOL_A_PMAX) begin
        pmax_reg <= pwdata;
      end else if (paddr == `SOL_A_PMIN) begin
        pmin_reg <= pwdata;
      end
    end
  end

  // assignment settings: written values wait for a supply restart
  generate
    for (genvar k = 0; k < `SOL_N_OUT; k++) begin : g_out
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_pend[k] <= `SOL_CODE_RST;
          out_act[k] <= `SOL_CODE_RST;
        end else begin
          if (wr_en && paddr == 8'(`SOL_A_OUT0 + 4 * k)) begin
            out_pend[k] <= pwdata[6:0];
          end
          if (power_cycle) begin
            out_act[k] <= out_pend[k];
          end
        end
      end
      // digital outputs only on the first two terminals
      sol_out_sel u_sel (
        .code(out_act[k]),
        .dout_ok(k < 2),
        .st(st),
        .level(sel[k])
      );
    end
    for (genvar j = 0; j < `SOL_N_IN; j++) begin : g_in
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_pend[j] <= `SOL_CODE_RST;
          in_act[j] <= `SOL_CODE_RST;
        end else begin
          if (wr_en && paddr == 8'(`SOL_A_IN0 + 4 * j)) begin
            in_pend[j] <= pwdata[6:0];
          end
          if (power_cycle) begin
            in_act[j] <= in_pend[j];
          end
        end
      end
    end
  endgenerate

  sol_in_map u_in (
    .cont_in(cont_in),
    .codes(in_act),
    .home_on(home_on),
    .pos_ok(pos_ok),
    .neg_ok(neg_ok)
  );

  // axis direction follows the rotation-direction setting
  // torque control bypasses both hardware limits
  always_comb begin
    travel_pos = ctrl_reg[`SOL_C_ROT] ? motor_rev : motor_fwd;
    travel_neg = ctrl_reg[`SOL_C_ROT] ? motor_fwd : motor_rev;
    pos_hit = !torque_mode && !pos_ok && travel_pos;
    neg_hit = !torque_mode && !neg_ok && travel_neg;
  end

  // software window: set wins over the clear by reverse travel
  always_comb begin
    sw_pos_next = sw_pos_reg;
    sw_neg_next = sw_neg_reg;
    if (!ctrl_reg[`SOL_C_SWEN]) begin
      sw_pos_next = 1'b0;
      sw_neg_next = 1'b0;
    end else begin
      if (cur_pos > pmax_reg) begin
        sw_pos_next = 1'b1;
      end else if (travel_neg) begin
        sw_pos_next = 1'b0;
      end
      if (cur_pos < pmin_reg) begin
        sw_neg_next = 1'b1;
      end else if (travel_pos) begin
        sw_neg_next = 1'b0;
      end
    end
  end

  // limit state, stop request and per-direction inhibits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ot_reg <= 1'b0;
      neg_ot_reg <= 1'b0;
      sw_pos_reg <= 1'b0;
      sw_neg_reg <= 1'b0;
      stop_req <= 1'b0;
      third_torque_limit_sel <= 1'b0;
      inhibit_pos <= 1'b0;
      inhibit_neg <= 1'b0;
      home_limit_switch <= 1'b0;
    end else begin
      pos_ot_reg <= pos_hit;
      neg_ot_reg <= neg_hit;
      sw_pos_reg <= sw_pos_next;
      sw_neg_reg <= sw_neg_next;
      stop_req <= pos_hit || neg_hit || sw_pos_next || sw_neg_next;
      third_torque_limit_sel <= ctrl_reg[`SOL_C_STOP];
      inhibit_pos <= pos_hit || sw_pos_next;
      inhibit_neg <= neg_hit || sw_neg_next;
      home_limit_switch <= home_on;
    end
  end

  // status bundle seen by the output selectors
  always_comb begin
    st = '0;
    st.rdy = servo_ready;
    st.inp = in_position;
    st.homed = homing_done;
    st.zspd = zero_speed;
    st.crdy = ctrl_ready;
    st.home = home_on;
    st.fstop = fstop_seen;
    st.preset = preset_done;
    st.alarm = alarm;
    st.pot = pos_ot_reg;
    st.nott = neg_ot_reg;
    st.ot = pos_ot_reg || neg_ot_reg || sw_pos_reg || sw_neg_reg;
    st.do1 = ctrl_reg[`SOL_C_DO1];
    st.do2 = ctrl_reg[`SOL_C_DO2];
  end

  // terminals driven from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_out <= '0;
    end else begin
      seq_out <= sel;
    end
  end

  // sticky events, write one to clear, a new event wins
  assign evt = {(sw_pos_next || sw_neg_next) && !(sw_pos_reg || sw_neg_reg),
                neg_hit && !neg_ot_reg, pos_hit && !pos_ot_reg};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      sts_reg <= (sts_reg & ~((wr_en && paddr == `SOL_A_STS) ? pwdata[2:0] : 3'h0)) | evt;
      irq <= |(((sts_reg & ~((wr_en && paddr == `SOL_A_STS) ? pwdata[2:0] : 3'h0)) | evt) & mask_reg);
    end
  end

  // assertions all run on the control clock and drop out during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // flag still set while travelling back inside the window
  sequence s_sw_above;
    sw_pos_reg && travel_neg && cur_pos <= pmax_reg;
  endsequence
  // a digital output code on a terminal that may not carry it
  sequence s_dout_bad;
    out_act[6] == `SOL_FC_DO1 || out_act[6] == `SOL_FC_DO2;
  endsequence

  // hardware limits: control mode, direction and stop method
  torque_ignore_a: assert property (torque_mode |=> !pos_ot_reg && !neg_ot_reg)
    else $error("limit acted under torque control");
  pos_direction_a: assert property (pos_ot_reg |-> $past(travel_pos) && !$past(pos_ok))
    else $error("positive limit without positive travel");
  neg_direction_a: assert property (neg_ot_reg |-> $past(travel_neg) && !$past(neg_ok))
    else $error("negative limit without negative travel");
  stop_cause_a: assert property ((pos_hit || neg_hit) |=> stop_req ##0 $past(ctrl_reg[`SOL_C_STOP]) == third_torque_limit_sel)
    else $error("limit hit without stop request");
  opposite_free_a: assert property ((pos_ot_reg && !sw_neg_reg && !neg_ot_reg) |-> !inhibit_neg)
    else $error("opposite motion blocked at limit");

  // output mapping and restart behaviour
  alarm_nc_a: assert property (out_act[8] == `SOL_FC_ALM_NC |=> seq_out[8] == !$past(alarm))
    else $error("closed-contact alarm output wrong");
  dout_limit_a: assert property (s_dout_bad |=> !seq_out[6])
    else $error("digital output on seventh terminal");
  unused_out_a: assert property (out_act[11] == `SOL_CODE_RST |=> !seq_out[11])
    else $error("unassigned output active");
  apply_power_a: assert property (out_act[0] != $past(out_act[0]) |-> $past(power_cycle))
    else $error("assignment changed without restart");
  pos_report_a: assert property (out_act[2] == `SOL_FC_POT |=> seq_out[2] == $past(pos_ot_reg))
    else $error("positive limit report wrong");

  // software window
  sw_clear_a: assert property (s_sw_above ##0 !(cur_pos > pmax_reg) |=> !sw_pos_reg)
    else $error("software limit kept on reverse travel");
  sw_window_a: assert property ((ctrl_reg[`SOL_C_SWEN] && cur_pos > pmax_reg) |=> stop_req && st.ot)
    else $error("window exit not stopped");

  // home switch and combined limit output
  home_map_a: assert property (home_limit_switch == $past(home_on))
    else $error("home switch not forwarded");
  ot_combined_a: assert property ((pos_ot_reg || sw_neg_reg) |-> st.ot)
    else $error("combined limit output missing");
endmodule : sol_seq_io

// ---- verification/sol_host_model.sv ----
// host controller and limit switch model on the far side of the sequence i/o block
`timescale 1ns/1ps
module sol_host_model #(
  parameter int POS_SW = 100, // positive switch opens at or above this
  parameter int NEG_SW = -100, // negative switch opens at or below this
  parameter int HOME_W = 5 // home switch closed within this of zero
) (
  input wire logic pclk, // control clock
  input wire logic presetn, // async reset, low active
  input wire logic go_pos, // host commands positive travel
  input wire logic go_neg, // host commands negative travel
  input wire logic rot_rev, // positive travel is reverse rotation
  input wire logic load, // load a new axis position
  input wire sol_pkg::sol_pos_type load_pos, // position to load
  input wire logic inhibit_pos, // device blocks positive commands
  input wire logic inhibit_neg, // device blocks negative commands
  output logic [5:0] cont_in, // input terminal levels
  output logic motor_fwd, // forward rotation
  output logic motor_rev, // reverse rotation
  output sol_pkg::sol_pos_type cur_pos // axis position
);
  import sol_pkg::*;
  logic [2:0] spare_reg; // changing level on terminals with no function
  // axis moves one count a cycle unless the device blocks that direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_pos <= '0;
      spare_reg <= 3'h0;
    end else begin
      spare_reg <= spare_reg + 3'h1;
      if (load) begin
        cur_pos <= load_pos;
      end else if (go_pos && !inhibit_pos) begin
        cur_pos <= cur_pos + 32'sh1;
      end else if (go_neg && !inhibit_neg) begin
        cur_pos <= cur_pos - 32'sh1;
      end
    end
  end
  // break contacts: a switch opens once the axis reaches it
  assign cont_in[0] = (cur_pos < POS_SW);
  assign cont_in[1] = (cur_pos > NEG_SW);
  // home switch closes near zero, used by the host's homing run
  assign cont_in[2] = (cur_pos >= -HOME_W) && (cur_pos <= HOME_W);
  assign cont_in[5:3] = spare_reg;
  // motor rotation follows the rotation direction setting
  assign motor_fwd = rot_rev ? go_neg : go_pos;
  assign motor_rev = rot_rev ? go_pos : go_neg;
endmodule : sol_host_model

// ---- verification/sol_seq_io_tb.sv ----
// self-checking testbench of the sequence i/o and over-travel block
`timescale 1ns/1ps
`include "sol_map.svh"
module sol_seq_io_tb;
  import sol_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, power_cycle; // bus and supply
  logic [7:0] paddr; // bus address
  logic [31:0] pwdata, prdata, rd; // bus data, last read word
  logic [5:0] cont_in; // terminal levels from the model
  logic motor_fwd, motor_rev, torque_mode, go_pos, go_neg, rot_rev, load, alarm; // motion controls
  sol_pos_type cur_pos, load_pos; // axis position
  logic [6:0] st_v; // status levels
  logic [11:0] seq_out; // output terminals
  logic home_limit_switch, stop_req, third_torque_limit_sel, inhibit_pos, inhibit_neg, irq; // device outputs
  int fail_count = 0; // mismatches
  int cmp_count = 0; // comparisons
  int cycles = 0; // run length
  sol_code_type codes [2][12] = '{ // two output assignment rounds
    '{`SOL_FC_RDY, `SOL_FC_INP, `SOL_FC_HOMED, `SOL_FC_ZSPD, `SOL_FC_CRDY, `SOL_FC_FSTOP,
      `SOL_FC_PRESET, `SOL_FC_ALM_NO, `SOL_FC_ALM_NC, `SOL_FC_DO1, 7'h37, `SOL_CODE_RST},
    '{`SOL_FC_DO1, `SOL_FC_DO2, `SOL_FC_POT, `SOL_FC_NOT, `SOL_FC_OT, `SOL_FC_HOME,
      `SOL_FC_DO2, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00}};
  sol_seq_io i_sol_seq_io (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_cycle(power_cycle), .cont_in(cont_in), .motor_fwd(motor_fwd), .motor_rev(motor_rev),
    .torque_mode(torque_mode), .cur_pos(cur_pos), .servo_ready(st_v[0]), .in_position(st_v[1]),
    .homing_done(st_v[2]), .zero_speed(st_v[3]), .ctrl_ready(st_v[4]), .fstop_seen(st_v[5]),
    .preset_done(st_v[6]), .alarm(alarm), .seq_out(seq_out), .home_limit_switch(home_limit_switch),
    .stop_req(stop_req), .third_torque_limit_sel(third_torque_limit_sel), .inhibit_pos(inhibit_pos),
    .inhibit_neg(inhibit_neg), .irq(irq));
  sol_host_model i_sol_host_model (.pclk(pclk), .presetn(presetn), .go_pos(go_pos), .go_neg(go_neg),
    .rot_rev(rot_rev), .load(load), .load_pos(load_pos), .inhibit_pos(inhibit_pos),
    .inhibit_neg(inhibit_neg), .cont_in(cont_in), .motor_fwd(motor_fwd), .motor_rev(motor_rev),
    .cur_pos(cur_pos));
  // prints the counts and the verdict, then stops
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // compares one value, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, 1'b1, "bus answer");
  endtask : apb
  // reads a register and compares it
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rchk
  // writes one round of output assignments
  task automatic setcodes(input int r);
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, `SOL_A_OUT0 + 8'(4 * k), {25'h0, codes[r][k]});
    end
  endtask : setcodes
  // supply restart pulse, then time for outputs to follow
  task automatic pwr();
    @(posedge pclk);
    power_cycle <= 1'b1;
    @(posedge pclk);
    power_cycle <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pwr
  // puts the axis at a position with no travel
  task automatic place(input int p);
    @(posedge pclk);
    load <= 1'b1;
    load_pos <= p;
    go_pos <= 1'b0;
    go_neg <= 1'b0;
    @(posedge pclk);
    load <= 1'b0;
  endtask : place
  // commands travel for a number of cycles
  task automatic go(input logic dp, input logic dn, input int n);
    @(posedge pclk);
    go_pos <= dp;
    go_neg <= dn;
    repeat (n) @(posedge pclk);
  endtask : go
  // control clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // cuts a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("mismatch at %0t: run too long", $time);
      conclude();
    end
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, power_cycle, torque_mode, go_pos, go_neg, rot_rev, load, alarm} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    load_pos = '0;
    st_v = 7'h00;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`SOL_A_CTRL, 32'h0, "ctrl reset");
    rchk(`SOL_A_MASK, 32'h0, "mask reset");
    rchk(`SOL_A_PMAX, `SOL_PMAX_RST, "max limit reset");
    rchk(`SOL_A_PMIN, `SOL_PMIN_RST, "min limit reset");
    rchk(`SOL_A_OUT0 + 8'h2C, 32'h0, "last code reset");
    apb(1'b1, 8'hFC, 32'hFFFFFFFF);
    chk(err, 1'b1, "unmapped write error");
    rchk(8'hFC, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped read error");
    apb(1'b1, `SOL_A_LIVE, 32'h1F);
    rchk(`SOL_A_LIVE, 32'h0, "live read only");
    $display("test registers done");
    st_v <= 7'h7F;
    apb(1'b1, `SOL_A_CTRL, 32'h08);
    chk(third_torque_limit_sel, 1'b0, "quick-stop method");
    setcodes(0);
    repeat (4) @(posedge pclk);
    chk(seq_out, 12'h000, "codes still pending");
    pwr();
    chk(seq_out, 12'h17F, "status map");
    alarm <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(seq_out, 12'h0FF, "alarm contacts");
    alarm <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      st_v <= 7'(1 << i);
      repeat (4) @(posedge pclk);
      chk(seq_out, 12'h100 | 12'(1 << i), "single status");
    end
    place(95);
    go(1'b1, 1'b0, 20);
    chk(stop_req, 1'b0, "unassigned limit reads on");
    place(0);
    repeat (3) @(posedge pclk);
    chk(home_limit_switch, 1'b0, "unassigned home off");
    $display("test output map done");
    setcodes(1);
    apb(1'b1, `SOL_A_IN0, 32'h7);
    apb(1'b1, `SOL_A_IN0 + 8'h04, 32'h8);
    apb(1'b1, `SOL_A_IN0 + 8'h08, 32'h6);
    apb(1'b1, `SOL_A_CTRL, 32'h1A);
    apb(1'b1, `SOL_A_MASK, 32'h7);
    pwr();
    chk(seq_out, 12'h023, "digital outputs and home");
    chk(home_limit_switch, 1'b1, "home switch");
    chk(third_torque_limit_sel, 1'b1, "stop method");
    for (int r = 0; r < 2; r++) begin
      rot_rev <= r[0];
      apb(1'b1, `SOL_A_CTRL, 32'h1A | r);
      place(95);
      go(1'b1, 1'b0, 20);
      chk({stop_req, inhibit_pos, inhibit_neg}, 3'b110, "positive limit stop");
      chk(seq_out[4:2], 3'b101, "positive limit outputs");
      chk(irq, 1'b1, "positive limit interrupt");
      go(1'b0, 1'b1, 20);
      chk({stop_req, inhibit_pos}, 2'b00, "positive limit released");
      apb(1'b1, `SOL_A_STS, 32'h1);
      rchk(`SOL_A_STS, 32'h0, "status cleared");
      chk(irq, 1'b0, "interrupt cleared");
    end
    rot_rev <= 1'b0;
    apb(1'b1, `SOL_A_CTRL, 32'h1A);
    place(110);
    go(1'b0, 1'b1, 3);
    chk(stop_req, 1'b0, "leaving positive limit");
    apb(1'b1, `SOL_A_MASK, 32'h5);
    place(-95);
    go(1'b0, 1'b1, 20);
    chk({stop_req, inhibit_pos, inhibit_neg}, 3'b101, "negative limit stop");
    chk(seq_out[4:2], 3'b110, "negative limit outputs");
    rchk(`SOL_A_STS, 32'h2, "negative event");
    chk(irq, 1'b0, "masked interrupt");
    go(1'b1, 1'b0, 20);
    apb(1'b1, `SOL_A_STS, 32'h2);
    apb(1'b1, `SOL_A_MASK, 32'h7);
    $display("test hardware limits done");
    torque_mode <= 1'b1;
    place(95);
    go(1'b1, 1'b0, 20);
    chk(stop_req, 1'b0, "torque mode ignores limits");
    torque_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(stop_req, 1'b1, "limit back after torque mode");
    go(1'b0, 1'b1, 30);
    apb(1'b1, `SOL_A_STS, 32'h7);
    $display("test torque mode done");
    apb(1'b1, `SOL_A_PMAX, 32'h28);
    apb(1'b1, `SOL_A_PMIN, 32'hFFFFFFD8);
    place(35);
    apb(1'b1, `SOL_A_CTRL, 32'h1E);
    go(1'b1, 1'b0, 20);
    chk(stop_req, 1'b1, "above window stop");
    chk(seq_out[4:2], 3'b100, "window outputs");
    rchk(`SOL_A_LIVE, 32'h4, "above window flag");
    go(1'b0, 1'b1, 30);
    rchk(`SOL_A_LIVE, 32'h0, "above flag cleared");
    chk(stop_req, 1'b0, "travel free again");
    place(-35);
    go(1'b0, 1'b1, 20);
    rchk(`SOL_A_LIVE, 32'h8, "below window flag");
    go(1'b1, 1'b0, 30);
    rchk(`SOL_A_LIVE, 32'h0, "below flag cleared");
    apb(1'b1, `SOL_A_CTRL, 32'h1A);
    place(35);
    go(1'b1, 1'b0, 20);
    chk(stop_req, 1'b0, "window disabled");
    $display("test software window done");
    conclude();
  end
endmodule : sol_seq_io_tb
